// [rtl/fsrg_gate.sv]
// Suspend and resume gate of a serial flash: instruction capture, gating and operation state.
// Assumes pins are synchronous to core_clk and sampled often enough to see every sck edge.
// Summary of operation
// RULE1 - Code 30 clears in erase suspend when enabled
// RULE2 - Code 82 clears status only in erase suspend
// RULE3 - Code 30 resumes when resume enable set
// RULE4 - Codes 7A, 8A always resume
// RULE5 - Array reads allowed in both suspend kinds
// RULE6 - Mode bit reset FF allowed in both
// RULE7 - Volatile protect access only in erase suspend
// RULE8 - Persistent protect reads only in erase suspend
// RULE9 - Reads inside suspended region flagged undefined
// RULE10 - Register writes and protect erase refused suspended
// RULE11 - Host guards nested-program sectors with volatile bits
// RULE12 - Nested program end returns to erase suspend
// RULE13 - Nested program reports busy like normal program
// RULE14 - Quad mode instruction byte takes two nibbles
// RULE15 - Resume sets busy, program resumes first
// RULE16 - Resume continues erase when no program suspended
// RULE17 - Resume with nothing suspended is ignored
// RULE18 - Host spaces resume and next suspend sometimes
// RULE19 - Suspend accepted right after resume, unlimited
// RULE20 - Host sends explicit resume after its work
// RULE21 - Codes 85, 75, B0 all suspend
// RULE22 - Second status bits show program, erase suspend
// RULE23 - New erase ignored while anything suspended
// RULE24 - Whole-array erase cannot be suspended
// RULE25 - Unlisted instructions ignored while suspended
`timescale 1ns/1ns
`include "fsrg_regs.svh"

module fsrg_gate
	import fsrg_pkg::*;
#(
	parameter int ADDR_W = 32,
	parameter int SECTOR_BITS = 18,
	parameter int PAGE_BITS = 8
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic [3:0] io_in,
	input wire logic quad_instruction_mode,
	input wire logic [7:0] config_three_nonvolatile,
	input wire logic [7:0] config_four_nonvolatile,
	input wire fsrg_op_s op_req,
	input wire logic [ADDR_W-1:0] op_addr,
	input wire logic rd_check,
	input wire logic [ADDR_W-1:0] rd_addr,
	output fsrg_cmd_s cmd,
	output fsrg_stat_s stat,
	output logic clear_status_cmd,
	output logic resume_cmd,
	output logic suspend_cmd,
	output logic run_program,
	output logic run_erase,
	output logic read_data_undefined
);

	fsrg_state_e state;
	fsrg_state_e next_state;
	logic sck_q;
	logic [2:0] bit_cnt;
	logic [7:0] shift;
	logic byte_seen;
	logic byte_done;
	logic [7:0] code;
	logic [ADDR_W-1:0] ers_addr;
	logic [ADDR_W-1:0] pgm_addr;
	logic ers_kind;
	logic pgm_kind;
	logic allowed;
	logic is_resume;
	logic is_suspend;
	logic is_clear;

	// Accept test for one instruction while suspended; erase_kind means only erase is held.
	function automatic logic fsrg_permit(input logic [7:0] op, input logic erase_kind,
		input logic res_en, input logic clr_en);
		logic ok;
		ok = 1'b0;
		case (op)
			`FSRG_OP_READ, `FSRG_OP_READ_W, `FSRG_OP_RDSTAT1, `FSRG_OP_RDSTAT2,
			`FSRG_OP_RDANY, `FSRG_OP_RST_ARM, `FSRG_OP_RST, `FSRG_OP_RESET:
				ok = 1'b1;
			`FSRG_OP_QREAD, `FSRG_OP_QREAD_W, `FSRG_OP_DREAD, `FSRG_OP_DREAD_W,
			`FSRG_OP_FREAD, `FSRG_OP_FREAD_W, `FSRG_OP_DDR, `FSRG_OP_DDR_W:
				ok = 1'b1; // RULE5
			`FSRG_OP_MODE_RST:
				ok = 1'b1; // RULE6
			`FSRG_OP_RES_A, `FSRG_OP_RES_B:
				ok = 1'b1; // RULE4
			`FSRG_OP_CLR_RES:
				ok = res_en | (erase_kind & clr_en); // RULE1 RULE3
			`FSRG_OP_CLR:
				ok = erase_kind; // RULE2
			`FSRG_OP_VPR, `FSRG_OP_VPW, `FSRG_OP_VPR_W, `FSRG_OP_VPW_W:
				ok = erase_kind; // RULE7
			`FSRG_OP_PPR, `FSRG_OP_PPR_W:
				ok = erase_kind; // RULE8
			`FSRG_OP_PROG, `FSRG_OP_PROG_W, `FSRG_OP_WREN:
				ok = erase_kind;
			`FSRG_OP_SUSP_A, `FSRG_OP_SUSP_B, `FSRG_OP_SUSP_C:
				ok = 1'b1;
			default:
				// Register writes and protect erase land here and are refused.
				ok = 1'b0; // RULE10 RULE25
		endcase
		return ok;
	endfunction

	function automatic logic fsrg_busy(input fsrg_state_e s);
		return (s == FSRG_PGM) || (s == FSRG_ERS) || (s == FSRG_BULK) || (s == FSRG_ERS_PGM);
	endfunction

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			sck_q <= 1'b0;
		else
			sck_q <= sck;
	end

	// Instruction byte capture; quad mode takes the high nibble first.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			bit_cnt <= 3'h0;
			shift <= 8'h00;
			byte_seen <= 1'b0;
			byte_done <= 1'b0;
			code <= 8'h00;
		end
		else
		begin
			byte_done <= 1'b0;
			if (cs_n)
			begin
				bit_cnt <= 3'h0;
				byte_seen <= 1'b0;
			end
			else if (sck && !sck_q && !byte_seen)
			begin
				if (quad_instruction_mode)
				begin
					shift <= {shift[3:0], io_in}; // RULE14
					if (bit_cnt == `FSRG_QUAD_BITS)
					begin
						code <= {shift[3:0], io_in}; // RULE14
						byte_done <= 1'b1;
						byte_seen <= 1'b1;
					end
				end
				else
				begin
					shift <= {shift[6:0], io_in[0]};
					if (bit_cnt == `FSRG_SINGLE_BITS)
					begin
						code <= {shift[6:0], io_in[0]};
						byte_done <= 1'b1;
						byte_seen <= 1'b1;
					end
				end
				bit_cnt <= 3'(bit_cnt + 3'h1);
			end
		end
	end

	assign ers_kind = (state == FSRG_ERS_SUSP) || (state == FSRG_ERS_PGM);
	assign pgm_kind = (state == FSRG_PGM_SUSP) || (state == FSRG_ERS_PGM_SUSP);
	assign allowed = !(ers_kind || pgm_kind) ||
		fsrg_permit(code, ers_kind, config_three_nonvolatile[`FSRG_CR3_RESUME_EN],
		config_four_nonvolatile[`FSRG_CR4_CLEAR_EN]);
	assign is_resume = byte_done && allowed && ((code == `FSRG_OP_RES_A) ||
		(code == `FSRG_OP_RES_B) ||
		((code == `FSRG_OP_CLR_RES) && config_three_nonvolatile[`FSRG_CR3_RESUME_EN]));
	assign is_clear = byte_done && allowed && !is_resume &&
		((code == `FSRG_OP_CLR_RES) || (code == `FSRG_OP_CLR));
	assign is_suspend = byte_done && allowed && ((code == `FSRG_OP_SUSP_A) ||
		(code == `FSRG_OP_SUSP_B) || (code == `FSRG_OP_SUSP_C)); // RULE21

	always_comb
	begin
		next_state = state;
		case (state)
			FSRG_IDLE:
			begin
				if (op_req.start_pgm)
					next_state = FSRG_PGM;
				else if (op_req.start_sector_erase)
					next_state = FSRG_ERS;
				else if (op_req.start_bulk)
					next_state = FSRG_BULK;
			end
			FSRG_PGM:
			begin
				if (op_req.done)
					next_state = FSRG_IDLE;
				else if (is_suspend)
					next_state = FSRG_PGM_SUSP; // RULE19
			end
			FSRG_ERS:
			begin
				if (op_req.done)
					next_state = FSRG_IDLE;
				else if (is_suspend)
					next_state = FSRG_ERS_SUSP; // RULE19
			end
			FSRG_BULK:
			begin
				// Suspend requests have no effect on a whole-array erase.
				if (op_req.done) // RULE24
					next_state = FSRG_IDLE;
			end
			FSRG_PGM_SUSP:
			begin
				if (is_resume)
					next_state = FSRG_PGM; // RULE15
			end
			FSRG_ERS_SUSP:
			begin
				// Erase starts are dropped; only a nested program may begin.
				if (is_resume)
					next_state = FSRG_ERS; // RULE16
				else if (op_req.start_pgm) // RULE23
					next_state = FSRG_ERS_PGM;
			end
			FSRG_ERS_PGM:
			begin
				if (op_req.done)
					next_state = FSRG_ERS_SUSP; // RULE12
				else if (is_suspend)
					next_state = FSRG_ERS_PGM_SUSP;
			end
			FSRG_ERS_PGM_SUSP:
			begin
				if (is_resume)
					next_state = FSRG_ERS_PGM; // RULE15
			end
			default:
				next_state = FSRG_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			state <= FSRG_IDLE;
		else
			state <= next_state;
	end

	// Status and engine controls follow the state that is being entered.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			stat <= '0;
			run_program <= 1'b0;
			run_erase <= 1'b0;
		end
		else
		begin
			stat.write_in_progress_flag <= fsrg_busy(next_state); // RULE13 RULE15 RULE17
			stat.second_status_register[`FSRG_STAT2_PGM_SUSP] <= (next_state == FSRG_PGM_SUSP) ||
				(next_state == FSRG_ERS_PGM_SUSP); // RULE22
			stat.second_status_register[`FSRG_STAT2_ERS_SUSP] <= (next_state == FSRG_ERS_SUSP) ||
				(next_state == FSRG_ERS_PGM) || (next_state == FSRG_ERS_PGM_SUSP); // RULE22
			run_program <= (next_state == FSRG_PGM) || (next_state == FSRG_ERS_PGM);
			run_erase <= (next_state == FSRG_ERS) || (next_state == FSRG_BULK);
		end
	end

	// Command report and action pulses, one cycle after the instruction byte completes.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cmd <= '0;
			clear_status_cmd <= 1'b0;
			resume_cmd <= 1'b0;
			suspend_cmd <= 1'b0;
		end
		else
		begin
			cmd.valid <= byte_done;
			cmd.allowed <= byte_done && allowed; // RULE25
			cmd.code <= code;
			clear_status_cmd <= is_clear; // RULE1 RULE2
			// Pulses only when a suspension is actually entered or left.
			resume_cmd <= is_resume && (pgm_kind || (state == FSRG_ERS_SUSP)); // RULE17
			suspend_cmd <= is_suspend && !op_req.done && fsrg_busy(state) && (state != FSRG_BULK);
		end
	end

	// Suspended region addresses, taken when each program or sector erase starts; a whole-array erase takes none.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ers_addr <= '0;
			pgm_addr <= '0;
		end
		else
		begin
			if ((state == FSRG_IDLE) && op_req.start_sector_erase && !op_req.start_pgm)
				ers_addr <= op_addr;
			if (op_req.start_pgm && ((state == FSRG_IDLE) || (state == FSRG_ERS_SUSP)))
				pgm_addr <= op_addr;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			read_data_undefined <= 1'b0;
		else
			read_data_undefined <= rd_check && ((stat.second_status_register[`FSRG_STAT2_ERS_SUSP] &&
				(rd_addr[ADDR_W-1:SECTOR_BITS] == ers_addr[ADDR_W-1:SECTOR_BITS])) ||
				(stat.second_status_register[`FSRG_STAT2_PGM_SUSP] &&
				(rd_addr[ADDR_W-1:PAGE_BITS] == pgm_addr[ADDR_W-1:PAGE_BITS]))); // RULE9
	end

endmodule

// [rtl/fsrg_pkg.sv]
// Types shared by the suspend gate and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
package fsrg_pkg;

	typedef enum logic [2:0]
	{
		FSRG_IDLE = 3'h0,
		FSRG_PGM = 3'h1,
		FSRG_ERS = 3'h2,
		FSRG_BULK = 3'h3,
		FSRG_PGM_SUSP = 3'h4,
		FSRG_ERS_SUSP = 3'h5,
		FSRG_ERS_PGM = 3'h6,
		FSRG_ERS_PGM_SUSP = 3'h7
	} fsrg_state_e;

	typedef struct packed
	{
		logic valid;
		logic allowed;
		logic [7:0] code;
	} fsrg_cmd_s;

	typedef struct packed
	{
		logic start_pgm;
		logic start_sector_erase;
		logic start_bulk;
		logic done;
	} fsrg_op_s;

	typedef struct packed
	{
		logic write_in_progress_flag;
		logic [1:0] second_status_register;
	} fsrg_stat_s;

endpackage

// [rtl/fsrg_regs.svh]
// Instruction codes, status bit positions and configuration bit positions of the suspend gate.
// Included by the gate module; holds definitions only.
`ifndef FSRG_REGS_SVH
`define FSRG_REGS_SVH

`define FSRG_OP_PROG 8'h02
`define FSRG_OP_READ 8'h03
`define FSRG_OP_RDSTAT1 8'h05
`define FSRG_OP_WREN 8'h06
`define FSRG_OP_RDSTAT2 8'h07
`define FSRG_OP_QREAD 8'h0B
`define FSRG_OP_QREAD_W 8'h0C
`define FSRG_OP_PROG_W 8'h12
`define FSRG_OP_READ_W 8'h13
`define FSRG_OP_CLR_RES 8'h30
`define FSRG_OP_RDANY 8'h65
`define FSRG_OP_RST_ARM 8'h66
`define FSRG_OP_SUSP_B 8'h75
`define FSRG_OP_RES_A 8'h7A
`define FSRG_OP_CLR 8'h82
`define FSRG_OP_SUSP_A 8'h85
`define FSRG_OP_RES_B 8'h8A
`define FSRG_OP_RST 8'h99
`define FSRG_OP_SUSP_C 8'hB0
`define FSRG_OP_DREAD 8'hBB
`define FSRG_OP_DREAD_W 8'hBC
`define FSRG_OP_VPR_W 8'hE0
`define FSRG_OP_VPW_W 8'hE1
`define FSRG_OP_PPR_W 8'hE2
`define FSRG_OP_FREAD 8'hEB
`define FSRG_OP_FREAD_W 8'hEC
`define FSRG_OP_DDR 8'hED
`define FSRG_OP_DDR_W 8'hEE
`define FSRG_OP_RESET 8'hF0
`define FSRG_OP_VPR 8'hFA
`define FSRG_OP_VPW 8'hFB
`define FSRG_OP_PPR 8'hFC
`define FSRG_OP_MODE_RST 8'hFF

`define FSRG_STAT2_PGM_SUSP 0
`define FSRG_STAT2_ERS_SUSP 1
`define FSRG_CR3_RESUME_EN 2
`define FSRG_CR4_CLEAR_EN 2
`define FSRG_SINGLE_BITS 3'h7
`define FSRG_QUAD_BITS 3'h1

`endif

// [verification/fsrg_gate_sva.sv]
// Checker for the suspend gate outputs.
// Bound to fsrg_gate and sees only its ports.
`timescale 1ns/1ns
module fsrg_gate_sva
	import fsrg_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire fsrg_cmd_s cmd,
	input wire fsrg_stat_s stat,
	input wire logic clear_status_cmd,
	input wire logic resume_cmd,
	input wire logic suspend_cmd,
	input wire logic run_program,
	input wire logic run_erase,
	input wire logic rd_check,
	input wire logic read_data_undefined
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);

	chk_refused_still: assert property (
		cmd.valid && !cmd.allowed |-> stat == $past(stat))
		else $error("refused code changed state");
	chk_suspend_flags: assert property (
		suspend_cmd |-> stat.second_status_register != 2'h0 && !stat.write_in_progress_flag)
		else $error("suspend without flag");
	chk_resume_busy: assert property (
		resume_cmd |-> cmd.valid && cmd.allowed && stat.write_in_progress_flag)
		else $error("resume without busy");
	chk_resume_none: assert property (
		resume_cmd |-> $past(stat.second_status_register) != 2'h0)
		else $error("resume with nothing suspended");
	chk_program_first: assert property (
		resume_cmd && $past(stat.second_status_register[0]) |-> run_program)
		else $error("program not resumed first");
	chk_erase_resume: assert property (
		resume_cmd && $past(stat.second_status_register) == 2'h2
		|-> run_erase && stat.second_status_register == 2'h0)
		else $error("erase not resumed");
	chk_clear_erase: assert property (
		clear_status_cmd |-> stat.second_status_register == 2'h2)
		else $error("clear outside erase suspend");
	chk_undef_idle: assert property (
		rd_check && stat.second_status_register == 2'h0 |=> !read_data_undefined)
		else $error("undefined read with nothing suspended");
endmodule

bind fsrg_gate fsrg_gate_sva i_sva
(
	.core_clk(core_clk), .rst(rst), .cmd(cmd), .stat(stat),
	.clear_status_cmd(clear_status_cmd), .resume_cmd(resume_cmd),
	.suspend_cmd(suspend_cmd), .run_program(run_program), .run_erase(run_erase),
	.rd_check(rd_check), .read_data_undefined(read_data_undefined)
);

// [verification/fsrg_gate_tb.sv]
// Self-checking bench for the suspend gate.
// Assumes the host model drives the serial pins and the bench drives the rest.
`timescale 1ns/1ns
module fsrg_gate_tb import fsrg_pkg::*;;
	logic core_clk = 1'h0;
	logic rst;
	logic cs_n;
	logic sck;
	logic [3:0] io_in;
	logic qmode;
	logic [7:0] cfg3;
	logic [7:0] cfg4;
	fsrg_op_s op_req;
	logic [31:0] op_addr;
	logic rd_check;
	logic [31:0] rd_addr;
	fsrg_cmd_s cmd;
	fsrg_stat_s stat;
	logic clear_status_cmd;
	logic resume_cmd;
	logic suspend_cmd;
	logic run_program;
	logic run_erase;
	logic read_data_undefined;
	int failures = 0;
	int check_count = 0;
	// Row: code, then flags {erase kind, cfg3 bit, cfg4 bit, allowed, resume, clear}.
	logic [15:0] rows [32] = '{16'h302D, 16'h3008, 16'h3020, 16'h8225, 16'h8200, 16'h3016,
		16'h3036, 16'h7A06, 16'h8A26, 16'h7A26, 16'h8A06, 16'h0B04, 16'hEB04, 16'hED04,
		16'h0C24, 16'hBB24, 16'hEC24, 16'hEE04, 16'hFF04, 16'hFF24, 16'hFA24, 16'hFB24,
		16'hE024, 16'hE124, 16'hFB00, 16'hE100, 16'hFC24, 16'hE224, 16'hFC00, 16'hE200,
		16'h0120, 16'h0100};
	logic [7:0] sus [3] = '{8'h85, 8'h75, 8'hB0};

	always #25 core_clk = ~core_clk;

	fsrg_gate i_dut
	(
		.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .io_in(io_in),
		.quad_instruction_mode(qmode), .config_three_nonvolatile(cfg3),
		.config_four_nonvolatile(cfg4), .op_req(op_req), .op_addr(op_addr),
		.rd_check(rd_check), .rd_addr(rd_addr), .cmd(cmd), .stat(stat),
		.clear_status_cmd(clear_status_cmd), .resume_cmd(resume_cmd),
		.suspend_cmd(suspend_cmd), .run_program(run_program), .run_erase(run_erase),
		.read_data_undefined(read_data_undefined)
	);

	fsrg_host_model i_host
	(
		.core_clk(core_clk), .quad_instruction_mode(qmode), .cs_n(cs_n), .sck(sck),
		.io_in(io_in)
	);

	task automatic end_sim;
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic op(input logic [3:0] o, input logic [31:0] a);
		@(posedge core_clk);
		#5 op_req = fsrg_op_s'(o);
		op_addr = a;
		@(posedge core_clk);
		#5 op_req = fsrg_op_s'(4'h0);
		repeat (2) @(negedge core_clk);
	endtask

	task automatic setup(input logic [1:0] c, input logic [3:0] o, input logic [31:0] a);
		@(posedge core_clk);
		#5 rst = 1'h1;
		cfg3 = {5'h0, c[1], 2'h0};
		cfg4 = {5'h0, c[0], 2'h0};
		@(posedge core_clk);
		#5 rst = 1'h0;
		op(o, a);
	endtask

	// Returns at the cycle in which the answer pulses stand.
	task automatic issue(input logic [7:0] c);
		int k;
		i_host.send(c);
		for (k = 0; k < 8 && cmd.valid !== 1'h1; k++)
			@(negedge core_clk);
		check("valid", 24'h1, 24'(cmd.valid));
		check("code", 24'(c), 24'(cmd.code));
	endtask

	task automatic rd(input logic [31:0] a, input logic e);
		@(posedge core_clk);
		#5 rd_check = 1'h1;
		rd_addr = a;
		@(posedge core_clk);
		@(negedge core_clk);
		check("undefined", 24'(e), 24'(read_data_undefined));
	endtask

	initial
	begin
		#500000;
		failures++;
		end_sim;
	end

	initial
	begin
		rst = 1'h1;
		qmode = 1'h0;
		cfg3 = 8'h0;
		cfg4 = 8'h0;
		op_req = fsrg_op_s'(4'h0);
		op_addr = 32'h0;
		rd_check = 1'h0;
		rd_addr = 32'h0;
		repeat (6) @(posedge core_clk);
		#5 rst = 1'h0;
		foreach (rows[i])
		begin
			setup(rows[i][4:3], rows[i][5] ? 4'h4 : 4'h8, 32'h0);
			issue(8'h85);
			issue(rows[i][15:8]);
			check("allowed", 24'(rows[i][2]), 24'(cmd.allowed));
			check("pulses", 24'(rows[i][1:0]), 24'({resume_cmd, clear_status_cmd}));
			check("stat", rows[i][1] ? 24'h4 : 24'(rows[i][5] ? 2'h2 : 2'h1), 24'(stat));
		end
		setup(2'h0, 4'h0, 32'h0);
		check("reset", 24'h0, 24'({cmd, stat, resume_cmd, suspend_cmd, run_program, run_erase}));
		issue(8'h7A);
		check("idle resume", 24'h0, 24'({resume_cmd, stat}));
		op(4'h2, 32'h0);
		issue(8'hB0);
		check("bulk suspend", 24'h4, 24'({suspend_cmd, stat}));
		setup(2'h0, 4'h8, 32'h0);
		@(posedge core_clk);
		#5 qmode = 1'h1;
		foreach (sus[i])
		begin
			issue(sus[i]);
			check("suspend", 24'h9, 24'({suspend_cmd, stat}));
			issue(8'h8A);
			check("resume", 24'h19, 24'({resume_cmd, stat, run_program}));
		end
		@(posedge core_clk);
		#5 qmode = 1'h0;
		setup(2'h0, 4'h4, 32'h0004_0000);
		issue(8'h75);
		op(4'h4, 32'h0);
		check("erase ignored", 24'h4, 24'({stat, run_erase}));
		op(4'h8, 32'h0008_0100);
		check("nested", 24'hD, 24'({stat, run_program}));
		issue(8'h85);
		check("nested suspend", 24'h3, 24'(stat));
		rd(32'h0007_FFFF, 1'h1);
		rd(32'h0008_01FF, 1'h1);
		rd(32'h0008_0200, 1'h0);
		issue(8'h7A);
		check("program first", 24'hD, 24'({stat, run_program}));
		op(4'h1, 32'h0);
		check("nested done", 24'h4, 24'({stat, run_program}));
		issue(8'h7A);
		check("erase resume", 24'h9, 24'({stat, run_erase}));
		end_sim;
	end
endmodule

// [verification/fsrg_host_model.sv]
// Host controller model that shifts one instruction byte per chip-select frame.
// Assumes core_clk is the bench clock and that the gate samples sck with it.
`timescale 1ns/1ns
module fsrg_host_model
(
	input wire logic core_clk,
	input wire logic quad_instruction_mode,
	output logic cs_n,
	output logic sck,
	output logic [3:0] io_in
);
	initial
	begin
		cs_n = 1'h1;
		sck = 1'h0;
		io_in = 4'h5;
	end

	// The clock stands low between frames; the lines show the inverse of their last value.
	task automatic send(input logic [7:0] code);
		int n;
		n = quad_instruction_mode ? 2 : 8;
		@(posedge core_clk);
		#5 cs_n = 1'h0;
		for (int i = 0; i < n; i++)
		begin
			@(posedge core_clk);
			#5 sck = 1'h0;
			io_in = quad_instruction_mode ? code[7-4*i -: 4] : {~io_in[3:1], code[7-i]};
			@(posedge core_clk);
			#5 sck = 1'h1;
		end
		@(posedge core_clk);
		#5 sck = 1'h0;
		@(posedge core_clk);
		#5 cs_n = 1'h1;
		io_in = ~io_in;
	endtask
endmodule
